// >>> src/tcc_regs.svh
// Register map, field positions, reset values and prescaler counts of the
// 16-bit timer with capture. Included by the timer package and top module.
// Operation
// - Filter needs four equal capture samples
// - Edge select bit chooses capture edge
// - Capture copies counter, sets capture flag
// - Capture-register TOP modes disable capture
// - Codes 0-5 stop or prescale clock
// - Codes 6/7 count external falling/rising
// - External pin counts even when output
// - Shared high-byte latch gives atomic counter
// - Counter write blocks next compare match
// - Compare registers continuously match counter
// - Compare high byte staged until low
// - Capture low read latches high byte
// - Comparator may replace capture pin
// - Capture irq needs mask5, global, flag
// - Compare A irq needs mask4, global, flag
// - Compare B irq needs mask3, global, flag
// - Overflow irq needs mask2, global, flag
// - Four mode bits pick sequence, TOP
// - Capture flag cleared by vector or one
`ifndef TCC_REGS_SVH
`define TCC_REGS_SVH

`define TCC_OFS_CTRLA 6'h00
`define TCC_OFS_CTRLB 6'h04
`define TCC_OFS_CNTL 6'h08
`define TCC_OFS_CNTH 6'h0C
`define TCC_OFS_CMPAL 6'h10
`define TCC_OFS_CMPAH 6'h14
`define TCC_OFS_CMPBL 6'h18
`define TCC_OFS_CMPBH 6'h1C
`define TCC_OFS_CAPL 6'h20
`define TCC_OFS_CAPH 6'h24
`define TCC_OFS_MASK 6'h28
`define TCC_OFS_FLAGS 6'h2C

`define TCC_B_FILTER 7
`define TCC_B_EDGE 6
`define TCC_B_RSVD 5
`define TCC_B_CAPSRC 2
`define TCC_B_CAP 5
`define TCC_B_CMPA 4
`define TCC_B_CMPB 3
`define TCC_B_OVF 2

`define TCC_CTRLB_WMASK 8'hDF
`define TCC_CTRLA_WMASK 8'h07
`define TCC_FLAG_MASK 8'h3C
`define TCC_RST_BYTE 8'h00
`define TCC_RST_WORD 16'h0000
`define TCC_FILTER_LEN 4

`define TCC_PRE_W 10
`define TCC_PRE_8 10'h007
`define TCC_PRE_64 10'h03F
`define TCC_PRE_256 10'h0FF
`define TCC_PRE_1024 10'h3FF

`define TCC_TOP_8 16'h00FF
`define TCC_TOP_9 16'h01FF
`define TCC_TOP_10 16'h03FF
`define TCC_TOP_MAX 16'hFFFF

`endif

// >>> src/tcc_pkg.sv
// Types of the 16-bit timer with capture: the whole register state.
// Assumes tcc_regs.svh is on the include path.
`include "tcc_regs.svh"
package tcc_pkg;

   typedef struct packed {
      logic [7:0] ctrlA;
      logic [7:0] ctrlB;
      logic [7:0] mask;
      logic [7:0] flags;
      logic [15:0] cnt;
      logic [15:0] cmpA;
      logic [15:0] cmpB;
      logic [15:0] cap;
      logic [7:0] temp;
      logic [`TCC_PRE_W-1:0] pre;
      logic countDown;
      logic blockCmp;
      logic capS1;
      logic capS2;
      logic [`TCC_FILTER_LEN-1:0] filtHist;
      logic capFilt;
      logic capPrev;
      logic extS1;
      logic extS2;
      logic extPrev;
      logic wrPend;
      logic [5:0] wrAddr;
      logic [31:0] rdata;
   } tcc_state_t;

endpackage : tcc_pkg

// >>> src/tcc_timer16.sv
// 16-bit timer/counter with input capture, two compares, AHB-Lite slave.
// Assumes single-word AHB-Lite transfers, inputs synchronous to mclk except
// the two pins, which are synchronised here.
//
// Design decisions made here: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "tcc_regs.svh"
module tcc_timer16 (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic captureInputPin,
   input wire logic comparatorOut,
   input wire logic externalCountPin,
   input wire logic globalIrqEnable,
   input wire logic [3:0] irqVectorAck,
   output logic captureIrq,
   output logic compareAIrq,
   output logic compareBIrq,
   output logic overflowIrq,
   output logic compareAMatch,
   output logic compareBMatch
);

   tcc_pkg::tcc_state_t st_r;
   tcc_pkg::tcc_state_t st_nxt;

   // TOP value of each waveform mode
   function automatic logic [15:0] topOf(input logic [3:0] m, input logic [15:0] a, input logic [15:0] c);
      case (m)
         4'h1, 4'h5: topOf = `TCC_TOP_8;
         4'h2, 4'h6: topOf = `TCC_TOP_9;
         4'h3, 4'h7: topOf = `TCC_TOP_10;
         4'h4, 4'h9, 4'hB, 4'hF: topOf = a;
         4'h8, 4'hA, 4'hC, 4'hE: topOf = c;
         default: topOf = `TCC_TOP_MAX;
      endcase
   endfunction : topOf

   function automatic logic isDual(input logic [3:0] m);
      isDual = (m inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB});
   endfunction : isDual

   function automatic logic isFast(input logic [3:0] m);
      isFast = (m inside {4'h5, 4'h6, 4'h7, 4'hE, 4'hF});
   endfunction : isFast

   logic [3:0] mode;
   logic [15:0] top;
   logic capTopMode;
   logic tick;
   logic capTrig;
   logic capSrc;
   logic extRise;
   logic extFall;
   logic addrPhase;
   logic [5:0] rdAddr;
   logic [7:0] wb;
   logic [7:0] setFlags;
   logic [7:0] clrFlags;
   logic cntWrite;

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = st_r.rdata;

   assign mode = {st_r.ctrlB[4:3], st_r.ctrlA[1:0]};
   assign top = topOf(mode, st_r.cmpA, st_r.cap);
   assign capTopMode = (mode == 4'h8) || (mode == 4'hA) || (mode == 4'hC) || (mode == 4'hE);

   assign extRise = st_r.extS2 & ~st_r.extPrev;
   assign extFall = ~st_r.extS2 & st_r.extPrev;

   always_comb begin
      case (st_r.ctrlB[2:0])
         3'h1: tick = 1'b1;
         // Low prescaler bits all ones mark one tick per divided period
         3'h2: tick = ((st_r.pre & `TCC_PRE_8) == `TCC_PRE_8);
         3'h3: tick = ((st_r.pre & `TCC_PRE_64) == `TCC_PRE_64);
         3'h4: tick = ((st_r.pre & `TCC_PRE_256) == `TCC_PRE_256);
         3'h5: tick = (st_r.pre == `TCC_PRE_1024);
         3'h6: tick = extFall;
         3'h7: tick = extRise;
         default: tick = 1'b0;
      endcase
   end

   // comparator may stand in for the pin
   assign capSrc = st_r.ctrlA[`TCC_B_CAPSRC] ? comparatorOut : st_r.capS2;
   // no capture while capture register is TOP
   assign capTrig = !capTopMode && (st_r.ctrlB[`TCC_B_EDGE] ? (st_r.capFilt & ~st_r.capPrev)
                                                              : (~st_r.capFilt & st_r.capPrev));

   assign addrPhase = hsel && hready && htrans[1];
   // Byte lanes ignored: every register sits in its own word
   assign rdAddr = {haddr[5:2], 2'b00};
   assign wb = hwdata[7:0];
   assign cntWrite = st_r.wrPend && (st_r.wrAddr == `TCC_OFS_CNTL);

   assign captureIrq = st_r.mask[`TCC_B_CAP] & globalIrqEnable & st_r.flags[`TCC_B_CAP];
   assign compareAIrq = st_r.mask[`TCC_B_CMPA] & globalIrqEnable & st_r.flags[`TCC_B_CMPA];
   assign compareBIrq = st_r.mask[`TCC_B_CMPB] & globalIrqEnable & st_r.flags[`TCC_B_CMPB];
   assign overflowIrq = st_r.mask[`TCC_B_OVF] & globalIrqEnable & st_r.flags[`TCC_B_OVF];

   assign compareAMatch = (st_r.cnt == st_r.cmpA);
   assign compareBMatch = (st_r.cnt == st_r.cmpB);

   always_comb begin
      st_nxt = st_r;
      setFlags = 8'h00;
      clrFlags = 8'h00;

      st_nxt.pre = st_r.pre + `TCC_PRE_W'(1);
      st_nxt.capS1 = captureInputPin;
      st_nxt.capS2 = st_r.capS1;
      st_nxt.extS1 = externalCountPin;
      st_nxt.extS2 = st_r.extS1;
      st_nxt.extPrev = st_r.extS2;

      // filter waits for four equal samples
      st_nxt.filtHist = {st_r.filtHist[`TCC_FILTER_LEN-2:0], capSrc};
      if (!st_r.ctrlB[`TCC_B_FILTER]) begin
         st_nxt.capFilt = capSrc;
      end else if (st_r.filtHist == {`TCC_FILTER_LEN{1'b1}}) begin
         st_nxt.capFilt = 1'b1;
      end else if (st_r.filtHist == {`TCC_FILTER_LEN{1'b0}}) begin
         st_nxt.capFilt = 1'b0;
      end
      st_nxt.capPrev = st_r.capFilt;

      // capture copies counter and flags it
      if (capTrig) begin
         st_nxt.cap = st_r.cnt;
         setFlags[`TCC_B_CAP] = 1'b1;
      end

      if (tick) begin
         st_nxt.blockCmp = 1'b0;
         // first tick after counter write has no match
         if (!st_r.blockCmp) begin
            setFlags[`TCC_B_CMPA] = compareAMatch;
            setFlags[`TCC_B_CMPB] = compareBMatch;
         end
         if (capTopMode && st_r.cnt == top) begin
            setFlags[`TCC_B_CAP] = 1'b1;
         end
         if (isDual(mode)) begin
            if (!st_r.countDown) begin
               if (st_r.cnt >= top) begin
                  st_nxt.countDown = 1'b1;
                  st_nxt.cnt = st_r.cnt - 16'h0001;
               end else begin
                  st_nxt.cnt = st_r.cnt + 16'h0001;
               end
            end else if (st_r.cnt == 16'h0000) begin
               st_nxt.countDown = 1'b0;
               st_nxt.cnt = 16'h0001;
               setFlags[`TCC_B_OVF] = 1'b1;
            end else begin
               st_nxt.cnt = st_r.cnt - 16'h0001;
            end
         end else begin
            st_nxt.countDown = 1'b0;
            st_nxt.cnt = (st_r.cnt == top) ? 16'h0000 : st_r.cnt + 16'h0001;
            if (isFast(mode) ? st_r.cnt == top : st_r.cnt == `TCC_TOP_MAX) begin
               setFlags[`TCC_B_OVF] = 1'b1;
            end
         end
      end

      clrFlags[5:2] = irqVectorAck;

      // Data phase of a write
      st_nxt.wrPend = 1'b0;
      if (st_r.wrPend) begin
         if (st_r.wrAddr == `TCC_OFS_CTRLA) begin
            st_nxt.ctrlA = wb & `TCC_CTRLA_WMASK;
         end else if (st_r.wrAddr == `TCC_OFS_CTRLB) begin
            st_nxt.ctrlB = wb & `TCC_CTRLB_WMASK;
         end else if (st_r.wrAddr == `TCC_OFS_CNTH || st_r.wrAddr == `TCC_OFS_CMPAH
                      || st_r.wrAddr == `TCC_OFS_CMPBH || st_r.wrAddr == `TCC_OFS_CAPH) begin
            // high byte staged in shared latch
            st_nxt.temp = wb;
         end else if (cntWrite) begin
            st_nxt.cnt = {st_r.temp, wb};
            st_nxt.blockCmp = 1'b1;
         end else if (st_r.wrAddr == `TCC_OFS_CMPAL) begin
            st_nxt.cmpA = {st_r.temp, wb};
         end else if (st_r.wrAddr == `TCC_OFS_CMPBL) begin
            st_nxt.cmpB = {st_r.temp, wb};
         end else if (st_r.wrAddr == `TCC_OFS_CAPL) begin
            st_nxt.cap = {st_r.temp, wb};
         end else if (st_r.wrAddr == `TCC_OFS_MASK) begin
            st_nxt.mask = wb;
         end else if (st_r.wrAddr == `TCC_OFS_FLAGS) begin
            clrFlags = clrFlags | (wb & `TCC_FLAG_MASK);
         end
      end

      // Set beats clear in the same cycle
      st_nxt.flags = ((st_r.flags & ~clrFlags) | setFlags) & `TCC_FLAG_MASK;

      // Address phase: read data and read side effects
      if (addrPhase) begin
         st_nxt.wrPend = hwrite;
         st_nxt.wrAddr = rdAddr;
         st_nxt.rdata = 32'h0000_0000;
         if (!hwrite) begin
            if (rdAddr == `TCC_OFS_CTRLA) begin
               st_nxt.rdata[7:0] = st_r.ctrlA;
            end else if (rdAddr == `TCC_OFS_CTRLB) begin
               st_nxt.rdata[7:0] = st_r.ctrlB;
            end else if (rdAddr == `TCC_OFS_CNTL) begin
               st_nxt.rdata[7:0] = st_r.cnt[7:0];
               st_nxt.temp = st_r.cnt[15:8];
            end else if (rdAddr == `TCC_OFS_CAPL) begin
               st_nxt.rdata[7:0] = st_r.cap[7:0];
               st_nxt.temp = st_r.cap[15:8];
            end else if (rdAddr == `TCC_OFS_CNTH || rdAddr == `TCC_OFS_CAPH) begin
               st_nxt.rdata[7:0] = st_r.temp;
            end else if (rdAddr == `TCC_OFS_CMPAL) begin
               st_nxt.rdata[7:0] = st_r.cmpA[7:0];
            end else if (rdAddr == `TCC_OFS_CMPAH) begin
               st_nxt.rdata[7:0] = st_r.cmpA[15:8];
            end else if (rdAddr == `TCC_OFS_CMPBL) begin
               st_nxt.rdata[7:0] = st_r.cmpB[7:0];
            end else if (rdAddr == `TCC_OFS_CMPBH) begin
               st_nxt.rdata[7:0] = st_r.cmpB[15:8];
            end else if (rdAddr == `TCC_OFS_MASK) begin
               st_nxt.rdata[7:0] = st_r.mask;
            end else if (rdAddr == `TCC_OFS_FLAGS) begin
               st_nxt.rdata[7:0] = st_r.flags;
            end
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         st_r <= '0;
      end else if (ce) begin
         st_r <= st_nxt;
      end
   end

endmodule : tcc_timer16

// >>> sim/tcc_timer16_props.sv
// Checker of bus answers and interrupt gating.
// Sees top ports only; bound at the foot.
`timescale 1ns/1ps
module tcc_timer16_props (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic globalIrqEnable,
   input wire logic captureIrq,
   input wire logic compareAIrq,
   input wire logic compareBIrq,
   input wire logic overflowIrq
);
   default clocking @(posedge mclk);
   endclocking
   default disable iff (!rst_b);
   logic rdReq;
   assign rdReq = hsel && hready && htrans[1] && !hwrite && ce;
   property p_capGate; captureIrq |-> globalIrqEnable; endproperty
   a_capGate: assert property (p_capGate) else $error("capture irq ungated");
   property p_cmpAGate; compareAIrq |-> globalIrqEnable; endproperty
   a_cmpAGate: assert property (p_cmpAGate) else $error("compare A irq ungated");
   property p_cmpBGate; !globalIrqEnable |-> !compareBIrq; endproperty
   a_cmpBGate: assert property (p_cmpBGate) else $error("compare B irq ungated");
   property p_ovfGate; overflowIrq |-> globalIrqEnable; endproperty
   a_ovfGate: assert property (p_ovfGate) else $error("overflow irq ungated");
   property p_rsvdRead; rdReq && haddr[5:0] == 6'h04 |=> !hrdata[5]; endproperty
   a_rsvdRead: assert property (p_rsvdRead) else $error("reserved bit read as one");
   property p_upperZero; rdReq |=> hrdata[31:8] == 24'h000000; endproperty
   a_upperZero: assert property (p_upperZero) else $error("upper read bits set");
   property p_unmapped; rdReq && haddr[5:0] >= 6'h30 |=> hrdata == 32'h00000000; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_zeroWait; hreadyout && !hresp; endproperty
   a_zeroWait: assert property (p_zeroWait) else $error("slave stalled or erred");
   c_cap: cover property ($rose(captureIrq));
   c_cmpA: cover property ($rose(compareAIrq));
   c_ovf: cover property ($rose(overflowIrq));
endmodule : tcc_timer16_props
bind tcc_timer16 tcc_timer16_props tcc_timer16_props_i (
   .mclk(mclk), .rst_b(rst_b), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .globalIrqEnable(globalIrqEnable),
   .captureIrq(captureIrq), .compareAIrq(compareAIrq), .compareBIrq(compareBIrq), .overflowIrq(overflowIrq)
);

// >>> sim/tcc_pin_model.sv
// Far-side pins: capture source and external count source.
// Edges land off the clock edge, as an unsynchronised driver would.
`timescale 1ns/1ps
module tcc_pin_model (
   input wire logic capLevel,
   input wire logic capGlitch,
   input wire logic extLevel,
   output logic captureInputPin,
   output logic externalCountPin
);
   assign #7 captureInputPin = capLevel ^ capGlitch;
   assign #13 externalCountPin = extLevel;
endmodule : tcc_pin_model

// >>> sim/tcc_timer16_tb.sv
// Bench of the 16-bit timer: table of register accesses, then hand tests.
// Waits on hready, so no slave latency is assumed; the pin model drives both pins.
`timescale 1ns/1ps
module tcc_timer16_tb;
   logic mclk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic globalIrqEnable = 1'b1, capLevel = 1'b1, capGlitch = 1'b0, extLevel = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [3:0] irqVectorAck = 4'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic hreadyout, hresp, captureIrq, compareAIrq, compareBIrq, overflowIrq;
   logic captureInputPin, externalCountPin;
   logic comparatorOut = 1'b0, compareAMatch, compareBMatch;
   logic [7:0] q;
   int errCount = 0, comparisons = 0;
   localparam int DIV [5] = '{1, 8, 64, 256, 1024};
   // Row: write nibble, offset, data or expected read
   // control B written with bit 5 zero
   localparam logic [19:0] ROWS [24] = '{20'h00400, 20'h02800, 20'h02C00, 20'h104DF, 20'h004DF,
      20'h128FF, 20'h028FF, 20'h10400, 20'h10C12, 20'h10834, 20'h00834, 20'h00C12, 20'h11477,
      20'h00C77, 20'h114A5, 20'h1105A, 20'h0105A, 20'h014A5, 20'h11CC3, 20'h1183C, 20'h0183C,
      20'h01CC3, 20'h130FF, 20'h03000};
   tcc_timer16 tcc_timer16_i (
      .mclk(mclk), .rst_b(rst_b), .ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .captureInputPin(captureInputPin), .comparatorOut(comparatorOut), .externalCountPin(externalCountPin),
      .globalIrqEnable(globalIrqEnable), .irqVectorAck(irqVectorAck), .captureIrq(captureIrq),
      .compareAIrq(compareAIrq), .compareBIrq(compareBIrq), .overflowIrq(overflowIrq),
      .compareAMatch(compareAMatch), .compareBMatch(compareBMatch)
   );
   tcc_pin_model tcc_pin_model_i (
      .capLevel(capLevel), .capGlitch(capGlitch), .extLevel(extLevel),
      .captureInputPin(captureInputPin), .externalCountPin(externalCountPin)
   );
   task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
      hsel <= 1'b1;
      haddr <= {26'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      do @(posedge mclk); while (hreadyout !== 1'b1);
      q = hrdata[7:0];
   endtask : bus
   task automatic wr16(input logic [5:0] a, input logic [15:0] v);
      bus(1'b1, a + 6'h04, v[15:8]);
      bus(1'b1, a, v[7:0]);
   endtask : wr16
   task automatic chkReg(input string n, input logic [7:0] e);
      comparisons++;
      if (q !== e) begin
         errCount++;
         $display("[ERR] %s exp %h got %h", n, e, q);
      end
   endtask : chkReg
   task automatic chkCnt(input logic [7:0] lo, input logic [7:0] hi);
      comparisons++;
      if ((q inside {[lo:hi]}) !== 1'b1) begin
         errCount++;
         $display("[ERR] count exp %h..%h got %h", lo, hi, q);
      end
   endtask : chkCnt
   task automatic chkIrq(input string n, input logic e, ref logic g);
      @(negedge mclk);
      comparisons++;
      if (g !== e) begin
         errCount++;
         $display("[ERR] %s exp %b got %b", n, e, g);
      end
      @(posedge mclk);
   endtask : chkIrq
   task automatic endSim();
      $display("checks %0d mismatches %0d", comparisons, errCount);
      if (errCount == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : endSim
   initial begin
      forever #20 mclk = ~mclk;
   end
   // Whole run is near 5800 cycles
   initial begin
      #800000;
      errCount++;
      endSim();
   end
   initial begin
      repeat (2) @(posedge mclk);
      rst_b <= 1'b1;
      @(posedge mclk);
      foreach (ROWS[i]) begin
         bus(ROWS[i][16], ROWS[i][13:8], ROWS[i][7:0]);
         if (!ROWS[i][16]) chkReg("table read", ROWS[i][7:0]);
      end
      $display("table done");
      foreach (DIV[c]) begin
         wr16(6'h08, 16'h0000);
         bus(1'b1, 6'h04, 8'(c + 1));
         repeat (4 * DIV[c] - 2) @(posedge mclk);
         bus(1'b1, 6'h04, 8'h00);
         bus(1'b0, 6'h08, 8'h00);
         chkCnt(8'h03, 8'h05);
      end
      $display("prescaler done");
      for (int c = 6; c < 8; c++) begin
         wr16(6'h08, 16'h0000);
         bus(1'b1, 6'h04, 8'(c));
         repeat (3) begin
            extLevel <= 1'b1;
            repeat (5) @(posedge mclk);
            extLevel <= 1'b0;
            repeat (5) @(posedge mclk);
         end
         repeat (6) @(posedge mclk);
         bus(1'b1, 6'h04, 8'h00);
         bus(1'b0, 6'h08, 8'h00);
         chkReg("external count", 8'h03);
      end
      $display("external count done");
      for (int e = 0; e < 2; e++) begin
         capLevel <= !e[0];
         wr16(6'h08, 16'h0042);
         bus(1'b1, 6'h04, {e[0], e[0], 6'h00});
         bus(1'b1, 6'h2C, 8'h20);
         capGlitch <= e[0];
         repeat (2) @(posedge mclk);
         capGlitch <= 1'b0;
         repeat (12) @(posedge mclk);
         chkIrq("capture early", 1'b0, captureIrq);
         capLevel <= e[0];
         repeat (12) @(posedge mclk);
         chkIrq("capture", 1'b1, captureIrq);
         bus(1'b0, 6'h20, 8'h00);
         chkReg("capture low", 8'h42);
         bus(1'b0, 6'h24, 8'h00);
         chkReg("capture high", 8'h00);
         globalIrqEnable <= 1'b0;
         chkIrq("capture gated", 1'b0, captureIrq);
         globalIrqEnable <= 1'b1;
         irqVectorAck <= 4'h8;
         @(posedge mclk);
         irqVectorAck <= 4'h0;
         capLevel <= !e[0];
         repeat (12) @(posedge mclk);
         chkIrq("capture other edge", 1'b0, captureIrq);
      end
      $display("capture done");
      wr16(6'h10, 16'h1000);
      wr16(6'h18, 16'h1001);
      for (int k = 0; k < 2; k++) begin
         wr16(6'h08, k ? 16'h0FFF : 16'h1000);
         chkIrq("match A", !k[0], compareAMatch);
         chkIrq("match B", 1'b0, compareBMatch);
         bus(1'b1, 6'h2C, 8'h3C);
         bus(1'b1, 6'h04, 8'h01);
         repeat (4) @(posedge mclk);
         bus(1'b1, 6'h04, 8'h00);
         chkIrq("compare A", k[0], compareAIrq);
         chkIrq("compare B", 1'b1, compareBIrq);
      end
      wr16(6'h08, 16'hFFFE);
      bus(1'b1, 6'h04, 8'h01);
      repeat (4) @(posedge mclk);
      bus(1'b1, 6'h04, 8'h00);
      chkIrq("overflow", 1'b1, overflowIrq);
      bus(1'b1, 6'h28, 8'h00);
      chkIrq("overflow masked", 1'b0, overflowIrq);
      $display("compare and overflow done");
      wr16(6'h08, 16'h0000);
      wr16(6'h20, 16'h0005);
      bus(1'b1, 6'h2C, 8'h3C);
      bus(1'b1, 6'h28, 8'h20);
      bus(1'b1, 6'h04, 8'h19);
      repeat (4) @(posedge mclk);
      bus(1'b1, 6'h04, 8'h00);
      chkIrq("flag at capture TOP", 1'b1, captureIrq);
      bus(1'b0, 6'h08, 8'h00);
      chkReg("count wrapped at TOP", 8'h00);
      bus(1'b1, 6'h2C, 8'h20);
      bus(1'b1, 6'h00, 8'h04);
      bus(1'b1, 6'h04, 8'h40);
      capLevel <= 1'b1;
      repeat (8) @(posedge mclk);
      chkIrq("pin while comparator", 1'b0, captureIrq);
      comparatorOut <= 1'b1;
      repeat (4) @(posedge mclk);
      chkIrq("comparator capture", 1'b1, captureIrq);
      $display("top and comparator done");
      bus(1'b1, 6'h04, 8'hC0);
      rst_b <= 1'b0;
      repeat (2) @(posedge mclk);
      rst_b <= 1'b1;
      @(posedge mclk);
      bus(1'b0, 6'h04, 8'h00);
      chkReg("control after reset", 8'h00);
      bus(1'b0, 6'h00, 8'h00);
      chkReg("control A after reset", 8'h00);
      $display("reset done");
      endSim();
   end
endmodule : tcc_timer16_tb
